/* pkg/wwdt_pkg.sv */
// Constants, offsets and types shared by the windowed watchdog block.
// Assumes an 8-bit register port with 20-bit addresses.
package wwdt_pkg;

  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 8;
  localparam int COUNT_W = 17;
  localparam int STAT_W  = 2;

  // Register addresses
  localparam logic [19:0] SERVICE_KEY_ADDR = 20'hFFFAB;
  localparam logic [19:0] IRQ_STATUS_ADDR  = 20'hFFFA0;
  localparam logic [19:0] IRQ_MASK_ADDR    = 20'hFFFA1;
  localparam logic [19:0] RESET_CAUSE_ADDR = 20'hFFFA2;
  localparam logic [19:0] OPTION_VIEW_ADDR = 20'hFFFA3;

  // Service key and read-back values
  localparam logic [7:0] KEY_SERVICE   = 8'hAC;
  localparam logic [7:0] KEY_READ_RUN  = 8'h9A;
  localparam logic [7:0] KEY_READ_STOP = 8'h1A;

  // Option byte fields
  localparam int OPT_IRQ_EN_BIT = 7;
  localparam int OPT_WIN_HI_BIT = 6;
  localparam int OPT_WIN_LO_BIT = 5;
  localparam int OPT_RUN_BIT    = 4;
  localparam int OPT_OVF_HI_BIT = 3;
  localparam int OPT_OVF_LO_BIT = 1;
  localparam int OPT_STBY_BIT   = 0;

  // Window codes
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h2;
  localparam logic [1:0] WIN_100 = 2'h3;

  // Reset cause and interrupt status layout
  localparam int RESET_CAUSE_REG_WDT_BIT   = 4;
  localparam int ST_INTERVAL    = 0;
  localparam int ST_WDT_TRIP    = 1;

  // Values after reset
  localparam logic [7:0]        OPT_RESET   = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RESET  = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RESET  = 2'h0;
  localparam logic [7:0]        RESET_CAUSE_REG_RESET  = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 17'h00000;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } wwdt_state_e;

endpackage

/* design/wwdt_edge_sync.sv */
// Three-stage synchroniser with rise and fall pulses for a slow pin clock.
// Assumes the pin toggles much slower than mclk.
`timescale 1ns/10ps
module wwdt_edge_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Pin side
  input  wire logic pin_in,
  // Pulses on mclk
  output logic      rise,
  output logic      fall
);

  logic [2:0] sync;
  logic [2:0] next_sync;
  logic       level;
  logic       next_level;
  logic       next_rise;
  logic       next_fall;

  // Stage 0 is only read by stage 1; a change counts once stages 1 and 2 agree
  always_comb begin
    next_sync  = {sync[1:0], pin_in};
    next_level = level;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    if ((sync[1] == sync[2]) && (sync[2] != level)) begin
      next_level = sync[2];
      next_rise  = sync[2];
      next_fall  = ~sync[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync  <= 3'h0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      sync  <= next_sync;
      level <= next_level;
      rise  <= next_rise;
      fall  <= next_fall;
    end
  end

endmodule

/* design/wwdt_top.sv */
// Windowed watchdog timer counting slow-oscillator cycles, with its
// register port, reset-cause flag and interval interrupt.
// Assumes the option byte is stable at reset release and that
// standby_mode comes from mclk-domain power control logic.
`timescale 1ns/10ps

// Overview of operation
// (RQ1) Count only on slow oscillator edges
// (RQ2) Counter is seventeen bits wide
// (RQ3) Overflow without service raises internal reset
// (RQ4) Bit access to key raises reset
// (RQ5) Wrong key byte raises reset
// (RQ6) Key write in closed window resets
// (RQ7) Watchdog reset sets reset cause bit four
// (RQ8) Interval interrupt at 75 percent plus half
// (RQ9) Option bits seven, six, five configure
// (RQ10) Option bits four, three-one, zero configure
// (RQ11) Correct key clears counter, counting resumes
// (RQ12) Key register reads 1A or 9A
// (RQ13) Key reads never return written value
// (RQ14) Software sets run bit to enable counting; here the run bit is option byte bit four, caught at load and not writable
// (RQ15) Selector picks overflow length power of two
// (RQ16) Window open 50, 75 or 100 percent
// (RQ17) First service after reset ignores window
// (RQ18) Standby stops counter unless standby run
// (RQ19) Run bit clear holds counter at zero
module wwdt_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Slow oscillator pin
  input  wire logic        low_osc_clk,
  // Configuration and power state
  input  wire logic [7:0]  option_byte,
  input  wire logic        standby_mode,
  // Register port
  input  wire logic [19:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_bit_op,
  output logic [7:0]       reg_rdata,
  // Results
  output logic             wdt_reset_req,
  output logic             irq
);

  wwdt_pkg::wwdt_state_e state;
  wwdt_pkg::wwdt_state_e next_state;

  logic [wwdt_pkg::COUNT_W-1:0] count;
  logic [wwdt_pkg::COUNT_W-1:0] next_count;
  logic [7:0]                   opt;
  logic [7:0]                   next_opt;
  logic                         first_done;
  logic                         next_first_done;
  logic                         next_reset_req;

  logic [wwdt_pkg::STAT_W-1:0]  status;
  logic [wwdt_pkg::STAT_W-1:0]  next_status;
  logic [wwdt_pkg::STAT_W-1:0]  mask;
  logic [wwdt_pkg::STAT_W-1:0]  next_mask;
  logic [7:0]                   reset_cause_reg;
  logic [7:0]                   next_reset_cause_reg;
  logic [7:0]                   next_rdata;
  logic                         next_irq;

  logic                         osc_rise;
  logic                         osc_fall;
  logic                         ev_interval;
  logic                         ev_trip;

  // Decoded option fields
  logic                         interval_irq_en;
  logic [1:0]                   open_period_sel;
  logic                         counter_run_en;
  logic [2:0]                   overflow_sel;
  logic                         standby_run_en;

  logic [wwdt_pkg::COUNT_W-1:0] top;
  logic [wwdt_pkg::COUNT_W-1:0] closed_len;
  logic [wwdt_pkg::COUNT_W-1:0] interval_pt;
  logic                         window_open;
  logic                         key_wr;
  logic                         key_bad;
  logic                         key_bit_err;
  logic                         key_data_err;
  logic                         key_window_err;
  logic                         stat_wr;
  logic                         mask_wr;

  // Overflow length in slow cycles for a selector code
  function automatic logic [wwdt_pkg::COUNT_W-1:0] ovf_len(input logic [2:0] sel);
    logic [wwdt_pkg::COUNT_W-1:0] one;
    one = 17'h00001;
    case (sel)
      3'h0:    ovf_len = one << 6;
      3'h1:    ovf_len = one << 7;
      3'h2:    ovf_len = one << 8;
      3'h3:    ovf_len = one << 9;
      3'h4:    ovf_len = one << 11;
      3'h5:    ovf_len = one << 13;
      3'h6:    ovf_len = one << 14;
      default: ovf_len = one << 16;
    endcase
  endfunction

  // Length of the closed part at the start of each period
  function automatic logic [wwdt_pkg::COUNT_W-1:0] closed_part(
    input logic [1:0]                   win,
    input logic [wwdt_pkg::COUNT_W-1:0] len
  );
    case (win)
      wwdt_pkg::WIN_50: closed_part = len >> 1;
      wwdt_pkg::WIN_75: closed_part = len >> 2;
      // Prohibited code behaves as fully open
      default:          closed_part = 17'h00000;
    endcase
  endfunction

  // Strobe qualified by an exact address match
  function automatic logic reg_hit(
    input logic        strobe,
    input logic [19:0] addr,
    input logic [19:0] target
  );
    reg_hit = strobe && (addr == target);
  endfunction

  wwdt_edge_sync i_wwdt_edge_sync (
    .mclk   (mclk),
    .srst   (srst),
    .pin_in (low_osc_clk),
    .rise   (osc_rise),
    .fall   (osc_fall)
  );

  always_comb begin
    interval_irq_en = opt[wwdt_pkg::OPT_IRQ_EN_BIT]; // RQ9
    open_period_sel = opt[wwdt_pkg::OPT_WIN_HI_BIT:wwdt_pkg::OPT_WIN_LO_BIT]; // RQ9
    counter_run_en  = opt[wwdt_pkg::OPT_RUN_BIT]; // RQ10
    overflow_sel    = opt[wwdt_pkg::OPT_OVF_HI_BIT:wwdt_pkg::OPT_OVF_LO_BIT]; // RQ10
    standby_run_en  = opt[wwdt_pkg::OPT_STBY_BIT]; // RQ10
    top             = ovf_len(overflow_sel); // RQ15
    closed_len      = closed_part(open_period_sel, top); // RQ16
    interval_pt     = top - (top >> 2);
    window_open     = (count >= closed_len); // RQ16
    key_wr          = reg_hit(reg_wr, reg_addr, wwdt_pkg::SERVICE_KEY_ADDR);
    stat_wr         = reg_hit(reg_wr, reg_addr, wwdt_pkg::IRQ_STATUS_ADDR);
    mask_wr         = reg_hit(reg_wr, reg_addr, wwdt_pkg::IRQ_MASK_ADDR);
    // Bit access and wrong data trip even while the counter is stopped
    key_bit_err     = reg_bit_op; // RQ4
    key_data_err    = (reg_wdata != wwdt_pkg::KEY_SERVICE); // RQ5
    // The window only binds once the first service after reset is done
    key_window_err  = first_done && !window_open; // RQ6 RQ17
    key_bad         = key_bit_err || key_data_err || key_window_err;
  end

  // Counter and sequencing
  always_comb begin
    next_state      = state;
    next_count      = count;
    next_opt        = opt;
    next_first_done = first_done;
    next_reset_req  = 1'b0;
    ev_interval     = 1'b0;
    ev_trip         = 1'b0;
    case (state)
      wwdt_pkg::ST_LOAD: begin
        // Option byte is caught one cycle after release, never under reset
        next_opt        = option_byte;
        next_count      = wwdt_pkg::COUNT_RESET;
        next_first_done = 1'b0;
        next_state      = wwdt_pkg::ST_RUN;
      end
      wwdt_pkg::ST_RUN: begin
        if (!counter_run_en) begin
          next_count = wwdt_pkg::COUNT_RESET; // RQ19
        end else if (standby_mode && !standby_run_en) begin
          next_state = wwdt_pkg::ST_HOLD; // RQ18
        end else begin
          if (osc_rise) begin // RQ1
            if (count == top - 17'h00001) begin
              ev_trip = 1'b1; // RQ3
            end else begin
              next_count = count + 17'h00001; // RQ2
            end
          end
          // Falling edge gives the extra half slow period
          if (osc_fall && interval_irq_en && (count == interval_pt)) begin
            ev_interval = 1'b1; // RQ8
          end
        end
      end
      wwdt_pkg::ST_HOLD: begin
        // Frozen in standby; cleared on wake so a whole period follows
        if (!standby_mode) begin
          next_count = wwdt_pkg::COUNT_RESET; // RQ18
          next_state = wwdt_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = wwdt_pkg::ST_LOAD;
      end
    endcase

    // Service wins over an overflow in the same cycle
    if (key_wr && (state != wwdt_pkg::ST_LOAD)) begin
      if (key_bad) begin
        ev_trip = 1'b1; // RQ4 RQ5 RQ6
      end else begin
        ev_trip         = 1'b0;
        next_count      = wwdt_pkg::COUNT_RESET; // RQ11
        next_first_done = 1'b1; // RQ17
      end
    end

    // A trip restarts the counter through ST_LOAD; status and reset cause only gain their trip bits, mask keeps its value
    if (ev_trip) begin
      next_reset_req = 1'b1; // RQ3
      next_count     = wwdt_pkg::COUNT_RESET;
      next_state     = wwdt_pkg::ST_LOAD;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state         <= wwdt_pkg::ST_LOAD;
      count         <= wwdt_pkg::COUNT_RESET;
      opt           <= wwdt_pkg::OPT_RESET;
      first_done    <= 1'b0;
      wdt_reset_req <= 1'b0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      opt           <= next_opt;
      first_done    <= next_first_done;
      wdt_reset_req <= next_reset_req;
    end
  end

  // Status, mask, reset cause and read port
  always_comb begin
    next_status = status;
    next_mask   = mask;
    next_reset_cause_reg   = reset_cause_reg;
    next_rdata  = 8'h00;
    // Mask and status share one layout: bit 0 interval, bit 1 trip
    if (stat_wr) begin
      next_status = status & ~reg_wdata[wwdt_pkg::STAT_W-1:0];
    end
    if (mask_wr) begin
      next_mask = reg_wdata[wwdt_pkg::STAT_W-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        wwdt_pkg::SERVICE_KEY_ADDR: begin
          next_rdata = counter_run_en ? wwdt_pkg::KEY_READ_RUN
                                      : wwdt_pkg::KEY_READ_STOP; // RQ12 RQ13
        end
        wwdt_pkg::IRQ_STATUS_ADDR: begin
          next_rdata = {6'h00, status};
        end
        wwdt_pkg::IRQ_MASK_ADDR: begin
          next_rdata = {6'h00, mask};
        end
        wwdt_pkg::RESET_CAUSE_ADDR: begin
          next_rdata = reset_cause_reg;
          // Cause flag clears on read so the next boot sees fresh state
          next_reset_cause_reg  = wwdt_pkg::RESET_CAUSE_REG_RESET;
        end
        wwdt_pkg::OPTION_VIEW_ADDR: begin
          next_rdata = opt;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (ev_interval) begin
      next_status[wwdt_pkg::ST_INTERVAL] = 1'b1; // RQ8
    end
    if (ev_trip) begin
      next_status[wwdt_pkg::ST_WDT_TRIP] = 1'b1;
      next_reset_cause_reg[wwdt_pkg::RESET_CAUSE_REG_WDT_BIT]  = 1'b1; // RQ7
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      status    <= wwdt_pkg::STAT_RESET;
      mask      <= wwdt_pkg::MASK_RESET;
      reset_cause_reg      <= wwdt_pkg::RESET_CAUSE_REG_RESET;
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      status    <= next_status;
      mask      <= next_mask;
      reset_cause_reg      <= next_reset_cause_reg;
      reg_rdata <= next_rdata;
      irq       <= next_irq;
    end
  end

endmodule

/* tb/wwdt_top_sva.sv */
// Concurrent checks on the watchdog register port, trip pulse and irq.
// Assumes it sees the ports of wwdt_top through the bind below.
`timescale 1ns/10ps
module wwdt_top_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Inputs of the block
  input wire logic        low_osc_clk,
  input wire logic [7:0]  option_byte,
  input wire logic        standby_mode,
  input wire logic [19:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_bit_op,
  // Outputs of the block
  input wire logic [7:0]  reg_rdata,
  input wire logic        wdt_reset_req,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic trip_seen;
  logic srst_d;
  wire key_wr = reg_wr && reg_addr == wwdt_pkg::SERVICE_KEY_ADDR;
  wire key_rd = reg_rd && reg_addr == wwdt_pkg::SERVICE_KEY_ADDR;
  wire cause_rd = reg_rd && reg_addr == wwdt_pkg::RESET_CAUSE_ADDR;
  wire mask_wr = reg_wr && reg_addr == wwdt_pkg::IRQ_MASK_ADDR;
  wire mask_off = mask_wr && reg_wdata[1:0] == 2'h0;
  // Key writes are ignored in the load cycle after srst or a trip
  wire key_live = key_wr && !srst_d && !wdt_reset_req;
  // A trip is owed to software until the cause register is read;
  // a read in the pulse cycle already sees and clears the flag
  always_ff @(posedge mclk) begin
    srst_d <= srst;
    if (srst)
      trip_seen <= 1'b0;
    else if (cause_rd)
      trip_seen <= 1'b0;
    else if (wdt_reset_req)
      trip_seen <= 1'b1;
  end
  sequence s_bad_key; key_live && reg_wdata != wwdt_pkg::KEY_SERVICE; endsequence
  sequence s_bit_key; key_live && reg_bit_op; endsequence
  // A key write just after the load cycle may trip again
  sequence s_quiet; !wdt_reset_req ##1 (!wdt_reset_req || $past(key_wr)); endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  property p_key_rd; key_rd |=> reg_rdata inside {8'h9A, 8'h1A}; endproperty
  property p_bad_key; s_bad_key |=> wdt_reset_req; endproperty
  property p_bit_key; s_bit_key |=> wdt_reset_req; endproperty
  property p_pulse; wdt_reset_req |=> s_quiet; endproperty
  property p_run_off; !option_byte[4] && !reg_wr |=> !wdt_reset_req; endproperty
  property p_mask_off; mask_off ##1 !mask_wr |=> !irq; endproperty
  property p_cause; cause_rd && trip_seen |=> reg_rdata[4]; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_key_rd: assert property (p_key_rd) else $error("key read value");
  a_bad_key: assert property (p_bad_key) else $error("wrong key kept");
  a_bit_key: assert property (p_bit_key) else $error("bit access kept");
  a_pulse: assert property (p_pulse) else $error("trip not a pulse");
  a_run_off: assert property (p_run_off) else $error("trip while off");
  a_mask_off: assert property (p_mask_off) else $error("irq not masked");
  a_cause: assert property (p_cause) else $error("cause flag missing");
endmodule

bind wwdt_top wwdt_top_sva i_wwdt_top_sva (
  .mclk(mclk), .srst(srst), .low_osc_clk(low_osc_clk), .option_byte(option_byte),
  .standby_mode(standby_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit_op(reg_bit_op), .reg_rdata(reg_rdata),
  .wdt_reset_req(wdt_reset_req), .irq(irq));

/* tb/wwdt_top_tb.sv */
// Self-checking bench for the windowed watchdog top.
// Assumes a free-running slow oscillator of 16 mclk cycles a period.
`timescale 1ns/10ps
module wwdt_top_tb;
  localparam logic [19:0] KEY = wwdt_pkg::SERVICE_KEY_ADDR;
  localparam logic [19:0] CAU = wwdt_pkg::RESET_CAUSE_ADDR;
  localparam logic [19:0] STA = wwdt_pkg::IRQ_STATUS_ADDR;
  localparam logic [7:0]  AC  = wwdt_pkg::KEY_SERVICE;
  logic        mclk = 1'b0, srst = 1'b1, low_osc_clk = 1'b0, standby_mode = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_bit_op = 1'b0, rd_d = 1'b0;
  logic [7:0]  option_byte = 8'hB0, reg_wdata = 8'h00, d, trips = 8'h00;
  logic [19:0] reg_addr = 20'h00000;
  logic [7:0]  reg_rdata, exp_q[$];
  logic        wdt_reset_req, irq;
  int          fails = 0, tests_run = 0, n;
  always #50 mclk = ~mclk;
  always #800 low_osc_clk = ~low_osc_clk;
  wwdt_top i_wwdt_top (.mclk(mclk), .srst(srst), .low_osc_clk(low_osc_clk),
    .option_byte(option_byte), .standby_mode(standby_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit_op(reg_bit_op),
    .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req), .irq(irq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (e !== s) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), reg_rdata);
    if (wdt_reset_req === 1'b1)
      trips++;
    rd_d = reg_rd;
  end
  task automatic wr(input logic [19:0] a, input logic [7:0] v, input logic b = 1'b0);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_bit_op <= b;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_bit_op <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic rst(input logic [7:0] o);
    @(posedge mclk);
    srst <= 1'b1;
    option_byte <= o;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic osc(input int k);
    repeat (k) @(posedge low_osc_clk);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  initial begin
    n = $urandom(63527);
    rst(8'hB0);
    rd(KEY, wwdt_pkg::KEY_READ_RUN);
    rd(wwdt_pkg::OPTION_VIEW_ADDR, 8'hB0);
    rd(CAU, 8'h00);
    rd(20'hFFFA4, 8'h00);
    $display("test reset values done");
    wr(KEY, AC);
    rd(KEY, wwdt_pkg::KEY_READ_RUN);
    osc(10);
    chk("trips", 8'h00, trips);
    wr(KEY, AC);
    wt(4);
    chk("trips", 8'h01, trips);
    rd(CAU, 8'h10);
    rd(CAU, 8'h00);
    rd(STA, 8'h02);
    $display("test closed window done");
    wr(KEY, AC);
    osc(40);
    wr(KEY, AC);
    wr(KEY, AC);
    wt(4);
    chk("trips", 8'h02, trips);
    $display("test service clear done");
    // Several wrong keys, each after the block has restarted
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      if (d == AC)
        d = 8'h00;
      wr(KEY, d);
      wt(4);
    end
    wr(KEY, AC, 1'b1);
    wt(4);
    chk("trips", 8'h06, trips);
    $display("test bad access done");
    wr(wwdt_pkg::IRQ_MASK_ADDR, 8'h01);
    wr(STA, 8'h03);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      wt(1);
      n++;
    end
    chk("irq time", 8'h01, {7'h00, n > 700 && n < 800});
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 2000) begin
      wt(1);
      n++;
    end
    chk("ovf time", 8'h01, {7'h00, n > 230 && n < 275});
    wr(STA, 8'h01);
    wt(3);
    chk("irq", 8'h00, {7'h00, irq});
    wr(wwdt_pkg::IRQ_MASK_ADDR, 8'h00);
    chk("trips", 8'h07, trips);
    $display("test overflow done");
    rst(8'h00);
    rd(KEY, wwdt_pkg::KEY_READ_STOP);
    osc(80);
    chk("trips", 8'h07, trips);
    rst(8'hB0);
    standby_mode <= 1'b1;
    osc(80);
    chk("trips", 8'h07, trips);
    standby_mode <= 1'b0;
    $display("test run off and standby done");
    // Window of 75 percent: closed for the first quarter
    rst(8'hD0);
    wr(KEY, AC);
    osc(8);
    wr(KEY, AC);
    wt(4);
    chk("trips", 8'h08, trips);
    wr(KEY, AC);
    osc(20);
    wr(KEY, AC);
    wt(4);
    chk("trips", 8'h08, trips);
    $display("test window 75 done");
    // Fully open window, 2^7 overflow, counting on through standby
    rst(8'hF3);
    standby_mode <= 1'b1;
    wr(KEY, AC);
    osc(5);
    wr(KEY, AC);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 3000) begin
      wt(1);
      n++;
    end
    chk("ovf time sel 1", 8'h01, {7'h00, n > 2020 && n < 2070});
    standby_mode <= 1'b0;
    wt(2);
    chk("trips", 8'h09, trips);
    $display("test open window and standby run done");
    wt(3);
    wrap_up();
  end
endmodule
